// [sram_port_ctrl.sv]
/*
 * One port of the synchronous dual-port static RAM: input registers,
 * address counter, storage array and flow-through or pipelined outputs.
 * Assumes a bus master on the same clk drives the synchronous inputs;
 * output_enable_n and output_latency_select are asynchronous levels.
 * The data pins are split into data_in, data_out and data_oe_n.
 */
`timescale 1ns/1ps

// Operation
// - deselect or byte off floats flow-through outputs next edge, pipelined the edge after
// - latency pin high pipelined, low flow-through
// - inputs sampled on rising edge, except two
// - strobe low loads external address every edge unless counter clear is low
// - pipelined read floats unselected byte lanes
// - pipelined outputs need two selected cycles
// - internal address is external or counter
// - counter clear adds no dead cycle
module dual_port_sram_port_control #(
	parameter int addr_w = sram_port_pkg::ADDR_W,
	parameter int data_w = sram_port_pkg::DATA_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// synchronous controls
	input wire logic chip_select_n,
	input wire logic chip_select_p,
	input wire logic upper_byte_sel_n,
	input wire logic lower_byte_sel_n,
	input wire logic write_en_n,
	input wire logic address_strobe_n,
	input wire logic counter_advance_n,
	input wire logic counter_clear_n,
	// synchronous address and write data
	input wire logic [addr_w-1:0] addr,
	input wire logic [data_w-1:0] data_in,
	// asynchronous controls
	input wire logic output_enable_n,
	input wire logic output_latency_select,
	// data pins, one enable per byte lane, low drives
	output logic [data_w-1:0] data_out,
	output logic [sram_port_pkg::BYTES-1:0] data_oe_n
);
	localparam int HALF = data_w / 2;

	// refuse at elaboration what the two-lane split and the array cannot serve
	if (data_w % 2 != 0 || addr_w < 1 || addr_w > 20)
	begin
		$error("dual_port_sram_port_control: unsupported width");
	end

	// byte enables decoded from the two low-active lane selects
	function automatic logic [sram_port_pkg::BYTES-1:0] lanes(input logic ub_n,
		input logic lb_n);
		logic [sram_port_pkg::BYTES-1:0] v;
		v = '0;
		v[sram_port_pkg::LANE_HI] = ~ub_n;
		v[sram_port_pkg::LANE_LO] = ~lb_n;
		return v;
	endfunction

	logic sel_q;
	logic we_q;
	logic strobe_n_q;
	logic adv_n_q;
	logic clr_n_q;
	logic [sram_port_pkg::BYTES-1:0] lane_q;
	logic [addr_w-1:0] addr_q;
	logic [data_w-1:0] din_q;
	logic [addr_w-1:0] cur_addr;
	logic [data_w-1:0] mem [0:(2**addr_w)-1];
	logic [data_w-1:0] flow_q;
	logic [data_w-1:0] pipe_q;
	logic [sram_port_pkg::BYTES-1:0] en_f_q;
	logic [sram_port_pkg::BYTES-1:0] en_p_q;
	logic sel_prev_q;
	logic both_sel_q;
	logic [sram_port_pkg::BYTES-1:0] en_sel;

	// registered inputs
	// every synchronous input is captured on the rising edge
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sel_q <= 1'b0;
			we_q <= 1'b0;
			strobe_n_q <= 1'b1;
			adv_n_q <= 1'b1;
			clr_n_q <= 1'b1;
			lane_q <= '0;
			addr_q <= sram_port_pkg::ADDR_RST;
			din_q <= '0;
		end
		else
		begin
			sel_q <= ~chip_select_n & chip_select_p;
			we_q <= ~write_en_n;
			strobe_n_q <= address_strobe_n;
			adv_n_q <= counter_advance_n;
			clr_n_q <= counter_clear_n;
			lane_q <= lanes(upper_byte_sel_n, lower_byte_sel_n);
			addr_q <= addr;
			din_q <= data_in;
		end
	end

	sram_addr_counter #(
		.addr_w(addr_w)
	) u_counter (
		.clk(clk),
		.resetn(resetn),
		.load_n(strobe_n_q),
		.advance_n(adv_n_q),
		.clear_n(clr_n_q),
		.ext_addr(addr_q),
		.cur_addr(cur_addr)
	);

	// byte-masked write; array holds no reset, like the real cells
	always_ff @(posedge clk)
	begin
		for (int b = 0; b < sram_port_pkg::BYTES; b++)
		begin
			if (sel_q && we_q && lane_q[b])
				mem[cur_addr][b*HALF +: HALF] <= din_q[b*HALF +: HALF];
		end
	end

	// read data: flow stage takes the array word, pipe stage one edge later
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			flow_q <= '0;
			pipe_q <= '0;
		end
		else
		begin
			flow_q <= mem[cur_addr];
			pipe_q <= flow_q;
		end
	end

	// lane enables off
	// deselection or an idle lane drops the enable at the next edge
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			en_f_q <= '0;
			sel_prev_q <= 1'b0;
		end
		else
		begin
			en_f_q <= (sel_q && !we_q) ? lane_q : '0;
			sel_prev_q <= sel_q;
		end
	end

	// two selected cycles
	// the lane mask travels with its word; a gap in selection blanks it
	// both_sel_q pairs this access with the one sampled an edge earlier
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			both_sel_q <= 1'b0;
			en_p_q <= '0;
		end
		else
		begin
			both_sel_q <= sel_q && sel_prev_q;
			en_p_q <= both_sel_q ? en_f_q : '0;
		end
	end

	// asynchronous pins
	// the two asynchronous pins must act without a clock edge, so this
	// output mux and enable gate are the only logic after the flops
	assign en_sel = output_latency_select ? en_p_q : en_f_q;
	assign data_out = output_latency_select ? pipe_q : flow_q;
	assign data_oe_n = output_enable_n ? sram_port_pkg::OE_OFF : ~en_sel;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	a_deselect_hiz: assert property (
		(chip_select_n || !chip_select_p) |-> ##2 (en_f_q == '0))
		else $error("flow enables stay on after deselect");

	a_deselect_pipe: assert property (
		(chip_select_n || !chip_select_p) |-> ##3 (en_p_q == '0))
		else $error("pipe enables stay on after deselect");

	a_pipe_data_mux: assert property (
		output_latency_select |-> (data_out == $past(flow_q)))
		else $error("pipelined output is not one stage behind flow");

	a_async_oe_off: assert property (
		output_enable_n |-> (data_oe_n == sram_port_pkg::OE_OFF))
		else $error("outputs driven while output enable is off");

	a_strobe_load: assert property (
		(!address_strobe_n && counter_clear_n) |-> ##1 (cur_addr == $past(addr)))
		else $error("external address not loaded under strobe");

	a_upper_lane_hiz: assert property (
		upper_byte_sel_n |-> ##3 !en_p_q[sram_port_pkg::LANE_HI])
		else $error("unselected upper lane enabled in pipelined read");

	a_pipe_two_cycles: assert property (
		(en_p_q != '0) |-> ($past(sel_q, 2) && $past(sel_q, 3)))
		else $error("pipelined outputs back after one selected cycle");

	a_counter_hold: assert property (
		(address_strobe_n && counter_advance_n && counter_clear_n)
		|-> ##1 (cur_addr == $past(cur_addr)))
		else $error("counter address moved while held");

	a_clear_no_gap: assert property (
		!counter_clear_n |-> ##1 (cur_addr == '0))
		else $error("counter clear did not address zero in its cycle");

	a_both_enables: assert property (
		(chip_select_n && chip_select_p) |-> ##2 (en_f_q == '0))
		else $error("port selected with one enable false");

	c_flow_read: cover property (
		!output_latency_select && !output_enable_n && data_oe_n == '0);
	c_pipe_read: cover property (
		output_latency_select && !output_enable_n && data_oe_n == '0);
	c_counter_step: cover property (
		address_strobe_n && !counter_advance_n ##1 address_strobe_n && !counter_advance_n);
endmodule

// [sram_addr_counter.sv]
/*
 * Shared constants for one port of the dual-port static RAM, and the
 * port's address counter.
 * Assumes every input arrives already registered on clk.
 * Assumes the port top instantiates exactly one counter.
 */
`timescale 1ns/1ps

package sram_port_pkg;
	// array shape
	localparam int ADDR_W = 16;
	localparam int DATA_W = 18;
	localparam int BYTES = 2;
	// byte lane positions in the byte-enable vectors
	localparam int LANE_LO = 0;
	localparam int LANE_HI = 1;
	// values after reset
	localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
	localparam logic [BYTES-1:0] OE_OFF = 2'h3;
	// output latency in cycles after the sampling edge
	localparam int FLOW_LAT = 1;
	localparam int PIPE_LAT = 2;
endpackage

module sram_addr_counter #(
	parameter int addr_w = sram_port_pkg::ADDR_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// registered controls, active low
	input wire logic load_n,
	input wire logic advance_n,
	input wire logic clear_n,
	input wire logic [addr_w-1:0] ext_addr,
	// address used by the access in this cycle
	output logic [addr_w-1:0] cur_addr
);
	logic [addr_w-1:0] cnt_q;

	// clear beats load, load beats advance; advance uses the next address now
	always_comb
	begin
		if (!clear_n)
			cur_addr = '0;
		else if (!load_n)
			cur_addr = ext_addr;
		else if (!advance_n)
			cur_addr = cnt_q + addr_w'(1);
		else
			cur_addr = cnt_q;
	end

	// counter follows the address just used, so a held strobe keeps state
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			cnt_q <= '0;
		else
			cnt_q <= cur_addr;
	end
endmodule

// [data_bus_model.sv]
/*
 * Partner model: the data bus as the port's master sees it.
 * Assumes per-lane active-low drive enables and equal-width lanes.
 */
`timescale 1ns/1ps
module data_bus_model (
	// device side
	input wire logic [sram_port_pkg::DATA_W-1:0] data_out,
	input wire logic [sram_port_pkg::BYTES-1:0] data_oe_n,
	// master side
	output logic [sram_port_pkg::DATA_W-1:0] bus
);
	localparam int LW = sram_port_pkg::DATA_W / sram_port_pkg::BYTES;
	logic [sram_port_pkg::DATA_W-1:0] last_q;
	// released lanes
	// a released lane shows its last value inverted, so stale data never matches
	always @(data_out or data_oe_n)
	begin
		for (int i = 0; i < sram_port_pkg::BYTES; i++)
		begin
			if (data_oe_n[i] == 1'b0)
				last_q[i*LW +: LW] = data_out[i*LW +: LW];
			bus[i*LW +: LW] = data_oe_n[i] ? ~last_q[i*LW +: LW] : data_out[i*LW +: LW];
		end
	end
endmodule

// [testbench.sv]
/*
 * Self-checking bench for one port: select table, counter, async enable,
 * pipelined reactivation. Assumes the bus model above on the data pins.
 */
`timescale 1ns/1ps
module testbench;
	logic clk, resetn, chip_select_n, chip_select_p, upper_byte_sel_n, lower_byte_sel_n;
	logic write_en_n, address_strobe_n, counter_advance_n, counter_clear_n;
	logic output_enable_n, output_latency_select;
	logic [15:0] addr;
	logic [17:0] data_in, data_out, bus;
	logic [1:0] data_oe_n;
	int err_total, checks, cyc;
	typedef struct {logic [3:0] sel; logic [1:0] en;} row_t;
	// {chip_select_n, chip_select_p, upper, lower} against lane enables
	row_t rows[7] = '{'{4'h4, 2'h0}, '{4'hc, 2'h3}, '{4'h0, 2'h3}, '{4'h8, 2'h3},
		'{4'h6, 2'h2}, '{4'h5, 2'h1}, '{4'h7, 2'h3}};
	dual_port_sram_port_control i_dut (.clk, .resetn, .chip_select_n, .chip_select_p,
		.upper_byte_sel_n, .lower_byte_sel_n, .write_en_n, .address_strobe_n,
		.counter_advance_n, .counter_clear_n, .addr, .data_in, .output_enable_n,
		.output_latency_select, .data_out, .data_oe_n);
	data_bus_model i_bus (.data_out, .data_oe_n, .bus);
	function automatic logic [17:0] word(input logic [15:0] a);
		return 18'h2a5a0 ^ {2'h0, a};
	endfunction
	// inputs change at the falling edge, away from sampling
	task automatic drive(input logic [3:0] s, input logic w, input logic [2:0] c, input logic [15:0] a);
		@(negedge clk);
		{chip_select_n, chip_select_p, upper_byte_sel_n, lower_byte_sel_n} = s;
		write_en_n = w;
		{address_strobe_n, counter_advance_n, counter_clear_n} = c;
		addr = a;
		data_in = word(a);
	endtask
	task automatic chk(input string what, input logic [17:0] e, input logic [17:0] g);
		checks++;
		if (g !== e)
		begin
			$display("[FAIL] %s expected %h seen %h", what, e, g);
			err_total++;
		end
	endtask
	// only enabled lanes carry data worth comparing
	task automatic look(input string what, input logic [1:0] en, input logic [15:0] a);
		logic [17:0] m;
		m = {{9{~en[1]}}, {9{~en[0]}}};
		chk({what, " enables"}, {16'h0, en}, {16'h0, data_oe_n});
		chk({what, " data"}, word(a) & m, bus & m);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// hang guard, the whole run needs well under 200 cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			err_total++;
			tally_and_finish();
		end
	end
	// main sequence
	initial
	begin
		resetn = 1'b0;
		{chip_select_n, chip_select_p, upper_byte_sel_n, lower_byte_sel_n} = 4'hc;
		{write_en_n, address_strobe_n, counter_advance_n, counter_clear_n} = 4'hf;
		addr = 16'h0000;
		data_in = 18'h00000;
		output_enable_n = 1'b0;
		output_latency_select = 1'b0;
		repeat (16) @(posedge clk);
		chk("reset enables", 18'h00003, {16'h0, data_oe_n});
		$display("test reset done");
		@(negedge clk);
		resetn = 1'b1;
		for (int i = 0; i < 4; i++)
			drive(4'h4, 1'b0, 3'h3, i[15:0]);
		for (int r = 0; r < 7; r++)
		begin
			drive(rows[r].sel, 1'b1, 3'h3, 16'h0003);
			drive(4'hc, 1'b1, 3'h7, 16'h0000);
			@(negedge clk);
			look("select row", rows[r].en, 16'h0003);
		end
		$display("test select table done");
		drive(4'h4, 1'b1, 3'h3, 16'h0001);
		drive(4'h4, 1'b1, 3'h5, 16'h0007);
		drive(4'h4, 1'b1, 3'h6, 16'h0007);
		look("strobe load", 2'h0, 16'h0001);
		drive(4'hc, 1'b1, 3'h7, 16'h0000);
		look("counter advance", 2'h0, 16'h0002);
		@(negedge clk);
		look("counter clear", 2'h0, 16'h0000);
		output_enable_n = 1'b1;
		#1 chk("async enable", 18'h00003, {16'h0, data_oe_n});
		// hold the pin off across one rising edge so the checker sees it
		@(negedge clk);
		output_enable_n = 1'b0;
		$display("test counter done");
		output_latency_select = 1'b1;
		drive(4'h4, 1'b1, 3'h3, 16'h0001);
		drive(4'hc, 1'b1, 3'h7, 16'h0000);
		repeat (2) @(negedge clk);
		look("isolated pipe", 2'h3, 16'h0001);
		drive(4'h4, 1'b1, 3'h3, 16'h0001);
		drive(4'h6, 1'b1, 3'h3, 16'h0002);
		drive(4'hc, 1'b1, 3'h7, 16'h0000);
		@(negedge clk);
		look("pipe first", 2'h3, 16'h0001);
		@(negedge clk);
		look("pipe lane", 2'h2, 16'h0002);
		$display("test pipelined done");
		tally_and_finish();
	end
endmodule
